/* File: hdl/pieb_map.svh */
// Register offsets, field positions, masks and reset values of the third enable bank.
// Assumes an 8-bit register port with 4-bit register addresses on one clock.
`ifndef PIEB_MAP_SVH
`define PIEB_MAP_SVH

`define PIEB_OFS_ENABLE3   4'h0
`define PIEB_OFS_PRIO1     4'h1
`define PIEB_OFS_PRIO2     4'h2
`define PIEB_OFS_PRIO3     4'h3
`define PIEB_OFS_STATUS    4'h4
`define PIEB_OFS_CLEAR     4'h5
`define PIEB_OFS_CTRL      4'h6

`define PIEB_BIT_DISPLAY   6
`define PIEB_BIT_RX2       5
`define PIEB_BIT_TX2       4
`define PIEB_BIT_CC2       2
`define PIEB_BIT_CC1       1
`define PIEB_BIT_GLOBAL_PRIORITY_ENABLE      0

`define PIEB_EN3_IMPL      8'h76
`define PIEB_EN3_WMASK     8'h46
`define PIEB_EN3_RESET     8'h00
`define PIEB_PRIO1_MASK    8'h7B
`define PIEB_PRIO2_MASK    8'hCE
`define PIEB_PRIO3_MASK    8'h76
`define PIEB_PRIO1_RESET   8'h7B
`define PIEB_PRIO2_RESET   8'hCE
`define PIEB_PRIO3_RESET   8'h76
`define PIEB_CTRL_RESET    1'b0

`endif

/* File: hdl/pieb_pkg.sv */
// State types of the third enable bank modules.
// Assumes eight-bit registers; the priority enable and the request states are single bits.
package pieb_pkg;
    typedef struct packed {
        logic [7:0] enable3;
        logic [7:0] prio1;
        logic [7:0] prio2;
        logic [7:0] prio3;
        logic       global_priority_enable;
        logic [7:0] rdata;
    } pieb_top_state_t;

    typedef struct packed {
        logic [7:0] status;
    } pieb_bank_state_t;

    typedef struct packed {
        logic irq;
        logic irq_high;
        logic irq_low;
    } pieb_route_state_t;
endpackage : pieb_pkg

/* File: hdl/pieb_src_if.sv */
// Carrier between the bank top, the sticky flag bank and the request router.
// Assumes all three sit on the same clock.
`timescale 1ns/1ns
interface pieb_src_if;
    logic [7:0] flag;
    logic       clr_stb;
    logic [7:0] clr_mask;
    logic [7:0] status;
    logic [7:0] enable;
    logic [7:0] prio;
    logic       global_priority_enable;
    logic       irq;
    logic       irq_high;
    logic       irq_low;

    modport top   (output flag, clr_stb, clr_mask, enable, prio, global_priority_enable,
                   input  status, irq, irq_high, irq_low);
    modport bank  (input  flag, clr_stb, clr_mask, output status);
    modport route (input  status, enable, prio, global_priority_enable, output irq, irq_high, irq_low);
endinterface : pieb_src_if

/* File: hdl/pieb_flag_bank.sv */
// Sticky per-source status flags of the third bank.
// Assumes flag pulses and clear strobes come from logic on the same clock.
`timescale 1ns/1ns
`include "pieb_map.svh"
module pieb_flag_bank (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    pieb_src_if.bank  src
);
    pieb_pkg::pieb_bank_state_t st;
    pieb_pkg::pieb_bank_state_t next_st;
    logic [7:0]                 next_bits;

    // A flag arriving with its clear is kept
    for (genvar g = 0; g < 8; g++) begin : g_bit
        assign next_bits[g] = src.flag[g] | (st.status[g] & ~(src.clr_stb & src.clr_mask[g]));
    end

    always_comb begin
        next_st        = st;
        next_st.status = next_bits & `PIEB_EN3_IMPL;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign src.status = st.status;

    set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (src.flag[`PIEB_BIT_CC1] && src.clr_stb) |=> st.status[`PIEB_BIT_CC1])
        else $error("flag lost when set met clear");
    clear_acts_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (src.clr_stb && (src.clr_mask == 8'hFF) && (src.flag == 8'h00)) |=> (st.status == 8'h00))
        else $error("clear did not empty status");
endmodule : pieb_flag_bank

/* File: hdl/pieb_prio_route.sv */
// Routes pending enabled sources onto the request outputs.
// Assumes status, enable and priority arrive from the same clock.
`timescale 1ns/1ns
module pieb_prio_route (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    pieb_src_if.route src
);
    pieb_pkg::pieb_route_state_t st;
    pieb_pkg::pieb_route_state_t next_st;
    logic [7:0]                  pend;

    assign pend = src.status & src.enable;

    always_comb begin
        next_st     = st;
        next_st.irq = |pend;
        if (src.global_priority_enable) begin
            next_st.irq_high = |(pend & src.prio);
            next_st.irq_low  = |(pend & ~src.prio);
        end else begin
            // Without priorities every source uses the single high vector
            next_st.irq_high = |pend;
            next_st.irq_low  = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign src.irq      = st.irq;
    assign src.irq_high = st.irq_high;
    assign src.irq_low  = st.irq_low;

    no_prio_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !$past(src.global_priority_enable) |-> !st.irq_low)
        else $error("low request while priorities are off");
    prio_split_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (src.global_priority_enable && ((pend & src.prio) == 8'h00) && (pend != 8'h00)) |=> (st.irq_low && !st.irq_high))
        else $error("low-priority source not routed low");
endmodule : pieb_prio_route

/* File: hdl/pieb_top.sv */
// Third peripheral interrupt enable bank with its three priority registers,
// sticky status, clear register and request outputs.
// Assumes a plain register port on clk_in; source flags and display mode come from same-clock logic.
`timescale 1ns/1ns
`include "pieb_map.svh"
module pieb_top (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       display_flag_in,
    input  wire logic       serial2_rx_flag_in,
    input  wire logic       serial2_tx_flag_in,
    input  wire logic       capcmp2_flag_in,
    input  wire logic       capcmp1_flag_in,
    input  wire logic       lcd_type_b_in,
    input  wire logic       lcd_nonstatic_in,
    input  wire logic       serial2_rx_irq_enable_in,
    input  wire logic       serial2_tx_irq_enable_in,
    output logic            irq_out,
    output logic            irq_high_out,
    output logic            irq_low_out,
    output logic      [7:0] priority_reg_first_out,
    output logic      [7:0] priority_reg_second_out,
    output logic      [7:0] priority_reg_third_out,
    output logic            global_priority_enable_out
);
    pieb_pkg::pieb_top_state_t st;
    pieb_pkg::pieb_top_state_t next_st;
    logic                      display_mode_ok;
    logic [7:0]                read_mux;
    logic [7:0]                flag_vec;
    logic [7:0]                enable_eff;

    pieb_src_if u_src ();

    // Display enable only counts in type-B waveform with non-static drive
    assign display_mode_ok = lcd_type_b_in & lcd_nonstatic_in;

    always_comb begin
        flag_vec                    = 8'h00;
        flag_vec[`PIEB_BIT_DISPLAY] = display_flag_in;
        flag_vec[`PIEB_BIT_RX2]     = serial2_rx_flag_in;
        flag_vec[`PIEB_BIT_TX2]     = serial2_tx_flag_in;
        flag_vec[`PIEB_BIT_CC2]     = capcmp2_flag_in;
        flag_vec[`PIEB_BIT_CC1]     = capcmp1_flag_in;
    end

    always_comb begin
        enable_eff                    = st.enable3;
        enable_eff[`PIEB_BIT_DISPLAY] = st.enable3[`PIEB_BIT_DISPLAY] & display_mode_ok;
    end

    assign u_src.flag     = flag_vec;
    assign u_src.clr_stb  = reg_wr_in && (reg_addr_in == `PIEB_OFS_CLEAR);
    assign u_src.clr_mask = reg_wdata_in;
    assign u_src.enable   = enable_eff;
    assign u_src.prio     = st.prio3;
    assign u_src.global_priority_enable     = st.global_priority_enable;

    always_comb begin
        read_mux = 8'h00;
        unique case (reg_addr_in)
            `PIEB_OFS_ENABLE3: begin
                read_mux = st.enable3 & `PIEB_EN3_IMPL;
            end
            `PIEB_OFS_PRIO1: begin
                read_mux = st.prio1;
            end
            `PIEB_OFS_PRIO2: begin
                read_mux = st.prio2;
            end
            `PIEB_OFS_PRIO3: begin
                read_mux = st.prio3;
            end
            `PIEB_OFS_STATUS: begin
                read_mux = u_src.status;
            end
            `PIEB_OFS_CTRL: begin
                read_mux[`PIEB_BIT_GLOBAL_PRIORITY_ENABLE] = st.global_priority_enable;
            end
            default: begin
                // Clear register and unmapped addresses read zero
                read_mux = 8'h00;
            end
        endcase
    end

    always_comb begin
        next_st       = st;
        next_st.rdata = reg_rd_in ? read_mux : 8'h00;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `PIEB_OFS_ENABLE3: begin
                    next_st.enable3 = reg_wdata_in & `PIEB_EN3_WMASK;
                end
                `PIEB_OFS_PRIO1: begin
                    next_st.prio1 = reg_wdata_in & `PIEB_PRIO1_MASK;
                end
                `PIEB_OFS_PRIO2: begin
                    next_st.prio2 = reg_wdata_in & `PIEB_PRIO2_MASK;
                end
                `PIEB_OFS_PRIO3: begin
                    next_st.prio3 = reg_wdata_in & `PIEB_PRIO3_MASK;
                end
                `PIEB_OFS_CTRL: begin
                    next_st.global_priority_enable = reg_wdata_in[`PIEB_BIT_GLOBAL_PRIORITY_ENABLE];
                end
                default: begin
                    // Status is read-only, clear acts in the flag bank
                    next_st.global_priority_enable = st.global_priority_enable;
                end
            endcase
        end
        // Serial port enables are owned by hardware; software writes never reach them
        next_st.enable3[`PIEB_BIT_RX2] = serial2_rx_irq_enable_in;
        next_st.enable3[`PIEB_BIT_TX2] = serial2_tx_irq_enable_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st.enable3 <= `PIEB_EN3_RESET;
            st.prio1   <= `PIEB_PRIO1_RESET;
            st.prio2   <= `PIEB_PRIO2_RESET;
            st.prio3   <= `PIEB_PRIO3_RESET;
            st.global_priority_enable    <= `PIEB_CTRL_RESET;
            st.rdata   <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    pieb_flag_bank u_bank (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .src      (u_src.bank)
    );

    pieb_prio_route u_route (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .src      (u_src.route)
    );

    assign reg_rdata_out              = st.rdata;
    assign irq_out                    = u_src.irq;
    assign irq_high_out               = u_src.irq_high;
    assign irq_low_out                = u_src.irq_low;
    assign priority_reg_first_out     = st.prio1;
    assign priority_reg_second_out    = st.prio2;
    assign priority_reg_third_out     = st.prio3;
    assign global_priority_enable_out = st.global_priority_enable;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    reserved_zero_a: assert property (
        (reg_rd_in && (reg_addr_in == `PIEB_OFS_ENABLE3))
        |=> ((reg_rdata_out & 8'h89) == 8'h00))
        else $error("unimplemented enable bit read nonzero");

    reserved_wr_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_ENABLE3) && (reg_wdata_in == 8'hFF))
        |=> ((st.enable3 & 8'h89) == 8'h00))
        else $error("unimplemented enable bit took a write");

    display_gate_a: assert property (
        (!display_mode_ok && ((u_src.status & st.enable3 & 8'hBF) == 8'h00))
        |=> !irq_out)
        else $error("display enable active outside type-B non-static");

    display_irq_a: assert property (
        (display_mode_ok && st.enable3[`PIEB_BIT_DISPLAY] && u_src.status[`PIEB_BIT_DISPLAY])
        |=> irq_out)
        else $error("enabled display flag raised no request");

    rx2_readonly_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_ENABLE3) && !serial2_rx_irq_enable_in)
        |=> !st.enable3[`PIEB_BIT_RX2])
        else $error("serial2 receive enable written by software");

    tx2_readonly_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_ENABLE3) && !serial2_tx_irq_enable_in)
        |=> !st.enable3[`PIEB_BIT_TX2])
        else $error("serial2 transmit enable written by software");

    capcmp_wr_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_ENABLE3))
        |=> (st.enable3[2:1] == $past(reg_wdata_in[2:1])))
        else $error("capture/compare enables not written");

    capcmp_irq_a: assert property (
        (!st.enable3[`PIEB_BIT_CC1] && !st.enable3[`PIEB_BIT_CC2] && ((u_src.status & enable_eff) == 8'h00))
        |=> !irq_out)
        else $error("request without enabled pending source");

    prio_write_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_PRIO3))
        |=> (priority_reg_third_out == ($past(reg_wdata_in) & `PIEB_PRIO3_MASK)))
        else $error("third priority register not written");

    prio_separate_a: assert property (
        (reg_wr_in && (reg_addr_in == `PIEB_OFS_PRIO1))
        |=> ($stable(priority_reg_second_out) && $stable(priority_reg_third_out)))
        else $error("priority registers not independent");

    global_priority_enable_gate_a: assert property (
        (!st.global_priority_enable && (u_src.status & enable_eff) != 8'h00)
        |=> (irq_high_out && !irq_low_out))
        else $error("priorities acted without global enable");

    read_timing_a: assert property (
        (reg_rd_in && (reg_addr_in == `PIEB_OFS_CTRL))
        |=> (reg_rdata_out == {7'h00, $past(st.global_priority_enable)}))
        else $error("control read data wrong or late");

    read_idle_a: assert property (
        !reg_rd_in |=> (reg_rdata_out == 8'h00))
        else $error("read data held outside read answer");
endmodule : pieb_top

/* File: dv/pieb_tb.sv */
// Self-checking bench for the third enable bank: register port, sticky status, clear and request routing.
// Assumes pieb_top on one 50 MHz clock; the bench drives every input itself.
`timescale 1ns/1ns
`include "pieb_map.svh"
module tb;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [4:0] flags = 5'h00;
    logic       lcd_type_b_in = 1'b0;
    logic       lcd_nonstatic_in = 1'b0;
    logic       rx_en_hw = 1'b0;
    logic       tx_en_hw = 1'b0;
    logic       irq_out;
    logic       irq_high_out;
    logic       irq_low_out;
    logic [7:0] prio_out [3];
    logic       gpe_out;
    int         n_fail = 0;
    int         num_checks = 0;
    int         cycles = 0;
    logic [7:0] rd_val;

    pieb_top u_dut (
        .clk_in                     (clk_in),
        .rst_n_in                   (rst_n_in),
        .reg_addr_in                (reg_addr_in),
        .reg_wdata_in               (reg_wdata_in),
        .reg_wr_in                  (reg_wr_in),
        .reg_rd_in                  (reg_rd_in),
        .reg_rdata_out              (reg_rdata_out),
        .display_flag_in            (flags[4]),
        .serial2_rx_flag_in         (flags[3]),
        .serial2_tx_flag_in         (flags[2]),
        .capcmp2_flag_in            (flags[1]),
        .capcmp1_flag_in            (flags[0]),
        .lcd_type_b_in              (lcd_type_b_in),
        .lcd_nonstatic_in           (lcd_nonstatic_in),
        .serial2_rx_irq_enable_in   (rx_en_hw),
        .serial2_tx_irq_enable_in   (tx_en_hw),
        .irq_out                    (irq_out),
        .irq_high_out               (irq_high_out),
        .irq_low_out                (irq_low_out),
        .priority_reg_first_out     (prio_out[0]),
        .priority_reg_second_out    (prio_out[1]),
        .priority_reg_third_out     (prio_out[2]),
        .global_priority_enable_out (gpe_out)
    );

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        @(negedge clk_in);
        rd_val = reg_rdata_out;
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle

    task automatic irq_chk(input logic [2:0] exp, input string msg);
        chk({5'h00, irq_out, irq_high_out, irq_low_out}, {5'h00, exp}, msg);
    endtask : irq_chk

    task automatic t_regs();
        logic [7:0] mask [3];
        mask = '{8'h7B, 8'hCE, 8'h76};
        rd(`PIEB_OFS_ENABLE3);
        chk(rd_val, 8'h00, "enable reset");
        for (int i = 0; i < 3; i++) begin
            rd(4'(i + 1));
            chk(rd_val, mask[i], "prio reset");
            wr(4'(i + 1), 8'h00);
            rd(4'(i + 1));
            chk(rd_val, 8'h00, "prio clear");
            wr(4'(i + 1), 8'hFF);
            rd(4'(i + 1));
            chk(rd_val, mask[i], "prio mask");
            chk(prio_out[i], mask[i], "prio port");
        end
        wr(`PIEB_OFS_ENABLE3, 8'hFF);
        rd(`PIEB_OFS_ENABLE3);
        chk(rd_val, 8'h46, "enable write ones");
        @(posedge clk_in);
        rx_en_hw <= 1'b1;
        tx_en_hw <= 1'b1;
        wr(`PIEB_OFS_ENABLE3, 8'h00);
        rd(`PIEB_OFS_ENABLE3);
        chk(rd_val, 8'h30, "enable hw bits");
        @(posedge clk_in);
        rx_en_hw <= 1'b0;
        tx_en_hw <= 1'b0;
        rd(4'hF);
        chk(rd_val, 8'h00, "unmapped read");
        rd(`PIEB_OFS_CTRL);
        chk(rd_val, 8'h00, "ctrl reset");
    endtask : t_regs

    task automatic t_events();
        wr(`PIEB_OFS_ENABLE3, 8'h02);
        @(posedge clk_in);
        flags <= 5'h01;
        @(posedge clk_in);
        flags <= 5'h00;
        @(negedge clk_in);
        irq_chk(3'b000, "irq too early");
        @(negedge clk_in);
        irq_chk(3'b110, "irq from cc1");
        wr(`PIEB_OFS_CLEAR, 8'h02);
        @(negedge clk_in);
        @(negedge clk_in);
        irq_chk(3'b000, "irq after clear");
        wr(`PIEB_OFS_ENABLE3, 8'h00);
        @(posedge clk_in);
        flags <= 5'h1F;
        @(posedge clk_in);
        flags <= 5'h00;
        settle();
        irq_chk(3'b000, "masked sources");
        wr(`PIEB_OFS_STATUS, 8'h00);
        rd(`PIEB_OFS_STATUS);
        chk(rd_val, 8'h76, "status all");
        wr(`PIEB_OFS_CLEAR, 8'hFF);
        rd(`PIEB_OFS_STATUS);
        chk(rd_val, 8'h00, "status cleared");
        // A flag arriving in the same cycle as its clear must survive
        @(posedge clk_in);
        flags <= 5'h01;
        wr(`PIEB_OFS_CLEAR, 8'h02);
        flags <= 5'h00;
        rd(`PIEB_OFS_STATUS);
        chk(rd_val, 8'h02, "flag kept over clear");
        wr(`PIEB_OFS_CLEAR, 8'hFF);
        rx_en_hw <= 1'b1;
        @(posedge clk_in);
        flags <= 5'h08;
        @(posedge clk_in);
        flags <= 5'h00;
        settle();
        irq_chk(3'b110, "serial2 receive irq");
        @(posedge clk_in);
        rx_en_hw <= 1'b0;
        settle();
        irq_chk(3'b000, "serial2 receive masked");
        wr(`PIEB_OFS_ENABLE3, 8'h04);
        @(posedge clk_in);
        flags <= 5'h02;
        @(posedge clk_in);
        flags <= 5'h00;
        settle();
        irq_chk(3'b110, "capcmp2 irq");
        wr(`PIEB_OFS_CLEAR, 8'hFF);
    endtask : t_events

    task automatic t_display();
        wr(`PIEB_OFS_ENABLE3, 8'h40);
        lcd_type_b_in <= 1'b1;
        @(posedge clk_in);
        flags <= 5'h10;
        @(posedge clk_in);
        flags <= 5'h00;
        settle();
        irq_chk(3'b000, "display static mode");
        @(posedge clk_in);
        lcd_nonstatic_in <= 1'b1;
        settle();
        irq_chk(3'b110, "display enabled");
        wr(`PIEB_OFS_CLEAR, 8'h40);
        settle();
        irq_chk(3'b000, "display cleared");
    endtask : t_display

    task automatic t_priority();
        wr(`PIEB_OFS_ENABLE3, 8'h02);
        @(posedge clk_in);
        flags <= 5'h01;
        @(posedge clk_in);
        flags <= 5'h00;
        wr(`PIEB_OFS_CTRL, 8'h01);
        settle();
        chk({7'h00, gpe_out}, 8'h01, "priority enable port");
        irq_chk(3'b110, "cc1 high priority");
        wr(`PIEB_OFS_PRIO3, 8'h74);
        settle();
        irq_chk(3'b101, "cc1 low priority");
        wr(`PIEB_OFS_CTRL, 8'h00);
        settle();
        irq_chk(3'b110, "priorities ignored");
    endtask : t_priority

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_in) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_events();
        t_display();
        t_priority();
        tally_and_finish();
    end
endmodule : tb
